// ### core/black_offset_cal.sv
// Purpose: optical-black averaging loop steering coarse and fine offset DACs
// Assumes: pins are asynchronous to aclk and pass two flip-flops
// Notes:   registers over AXI4-Lite and over a 3-wire serial port
// How it works
// - a falling black clamp pulse starts one calibration pass
// - line average of black samples is compared with the black target
// - offsets inside plus or minus 255 adjust only the fine DAC
// - larger offsets step the coarse DAC by one toward the residue
// - one fine DAC step equals one converter code
// - coarse step is linear gain times n, n set by gain code band
// - loop settles output black level to target within one code
// - weighted rolling average, factor 1 down to 1/128
// - hot or cold samples are replaced by the previous pixel
// - fast bit: first line of frame uses factor 1, no limits
// - two to the N black pixels per line, N from 0 to 6
// - automatic mode resumes from the DAC values last held
// - serial frame: two zeros, 4-bit address, 10 data bits
// - gain code is 10 bits, 0 to 767
`timescale 1ns/1ps
`default_nettype none
module black_offset_cal
   import offset_cal_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [7:0]  awaddr,
   input  wire logic        wvalid,
   output logic             wready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   output logic             bvalid,
   input  wire logic        bready,
   output logic [1:0]       bresp,
   input  wire logic        arvalid,
   output logic             arready,
   input  wire logic [7:0]  araddr,
   output logic             rvalid,
   input  wire logic        rready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   input  wire logic        black_clamp_pulse_n,
   input  wire logic        conversion_clock,
   input  wire logic        frame_start,
   input  wire logic [9:0]  adc_data,
   input  wire logic        serial_clk,
   input  wire logic        serial_cs_n,
   input  wire logic        serial_data_in,
   output logic [7:0]       coarse_offset_dac,
   output logic [9:0]       fine_offset_dac
);
   state_t             q;
   state_t             n;
   axi_t               keep;
   logic               clamp_fall;
   logic               conv_rise;
   logic               sclk_rise;
   logic               frame_rise;
   logic               axi_wr;
   logic               ser_wr;
   logic [15:0]        ser_word;
   logic               wr_en;
   logic [5:0]         wr_idx;
   logic [31:0]        wr_mask;
   logic [31:0]        wd;
   logic [2:0]         nlog;
   logic [6:0]         last;
   logic [9:0]         pix;
   logic [9:0]         line;
   logic signed [17:0] diff;
   logic [16:0]        avg_new;
   logic [10:0]        avg_int;
   logic signed [11:0] err;
   logic signed [11:0] fraw;
   logic signed [11:0] fnew;

   function automatic state_t rst_state();
      state_t s;
      s        = '0;
      s.s1     = 6'h09;
      s.s2     = 6'h09;
      s.s3     = 6'h09;
      s.ctrl   = ctrl_t'(CTRL_RST);
      s.target = TARGET_RST;
      s.hot    = HOT_RST;
      s.cold   = COLD_RST;
      s.gain   = GAIN_RST;
      s.st     = CAL_IDLE;
      return s;
   endfunction : rst_state

   function automatic logic [31:0] reg_read(state_t s, logic [5:0] idx);
      logic [31:0] v;
      v = '0;
      unique case ({idx, 2'b00})
         CTRL_OFS:   v[7:0] = s.ctrl;
         TARGET_OFS: v[9:0] = s.target;
         LIMIT_OFS:  v = {6'h0, s.hot, 6'h0, s.cold};
         GAIN_OFS:   v[9:0] = s.gain;
         COARSE_OFS: v[7:0] = s.coarse;
         FINE_OFS:   v[9:0] = s.fine;
         STATUS_OFS: begin
            v[9:0]      = s.avg[16:FRAC];
            v[BUSY_BIT]  = (s.st != CAL_IDLE);
            v[FIRST_BIT] = s.first;
         end
         default:    v = '0;
      endcase
      return v;
   endfunction : reg_read

   function automatic logic mapped(logic [5:0] idx);
      return {idx, 2'b00} <= STATUS_OFS;
   endfunction : mapped

   // gain roughly doubles every 128 codes, so the shift tracks linear gain
   function automatic logic [7:0] coarse_step(logic [9:0] g);
      logic [7:0] m;
      if (g < GAIN_N3)
         m = 8'h04;
      else if (g < GAIN_N2)
         m = 8'h03;
      else if (g < GAIN_N1)
         m = 8'h02;
      else
         m = 8'h01;
      return m << g[9:7];
   endfunction : coarse_step

   function automatic logic signed [9:0] sat_fine(logic signed [11:0] v);
      if (v > FINE_SPAN)
         return 10'(FINE_SPAN);
      if (v < -FINE_SPAN)
         return 10'(-FINE_SPAN);
      return v[9:0];
   endfunction : sat_fine

   assign clamp_fall = q.s3[0] & ~q.s2[0];
   assign conv_rise  = q.s2[1] & ~q.s3[1];
   assign sclk_rise  = q.s2[2] & ~q.s3[2];
   assign frame_rise = q.s2[5] & ~q.s3[5];

   always_comb begin
      n        = q;
      keep     = q.axi;
      pix      = q.px2;
      ser_word = {q.sh[14:0], q.s2[4]};
      nlog     = (q.ctrl.n_log > N_LOG_MAX) ? N_LOG_MAX : q.ctrl.n_log;
      last     = 7'((8'h01 << nlog) - 8'h01);
      line     = 10'(q.sum >> nlog);
      diff     = $signed({1'b0, line, 7'h00}) - $signed({1'b0, q.avg});
      avg_new  = 17'($signed({1'b0, q.avg})
                 + (diff >>> (q.first ? 3'h0 : q.ctrl.wshift)));
      avg_int  = {1'b0, avg_new[16:FRAC]} + {10'h0, avg_new[FRAC-1]};
      err      = $signed({1'b0, avg_int}) - $signed({2'b00, q.target});
      fraw     = 12'(q.fine) - err;
      fnew     = fraw;
      n.s1     = {frame_start, serial_data_in, serial_cs_n, serial_clk,
                  conversion_clock, black_clamp_pulse_n};
      n.s2     = q.s1;
      n.s3     = q.s2;
      n.px1    = adc_data;
      n.px2    = q.px1;

      ser_wr = 1'b0;
      if (q.s2[3]) begin
         n.bits = '0;
      end else if (sclk_rise) begin
         n.sh   = ser_word;
         n.bits = q.bits + 4'h1;
         ser_wr = (q.bits == 4'hf) && (ser_word[15:14] == 2'b00);
      end

      unique case (q.st)
         CAL_IDLE: begin
            if (clamp_fall && !q.ctrl.direct) begin
               n.st  = CAL_RUN;
               n.cnt = '0;
               n.sum = '0;
            end
         end
         CAL_RUN: begin
            if (conv_rise) begin
               // hot/cold replacement, suspended on fast line
               if (!q.first && (q.px2 > q.hot || q.px2 < q.cold))
                  pix = q.prev;
               n.prev = pix;
               n.sum  = q.sum + {6'h0, pix};
               n.cnt  = q.cnt + 7'h01;
               // window of two to the N pixels
               if (q.cnt == last)
                  n.st = CAL_UPDATE;
            end
         end
         CAL_UPDATE: begin
            // rolling average, factor 1 on first line
            n.avg   = avg_new;
            n.first = 1'b0;
            n.st    = CAL_IDLE;
            // one update per line, compare with target
            if (!q.ctrl.direct) begin
               // coarse step toward residue, step size
               if (fraw > FINE_SPAN && q.coarse != 8'sh7f) begin
                  n.coarse = q.coarse + 8'sh01;
                  fnew     = fraw - $signed({4'h0, coarse_step(q.gain)});
               end else if (fraw < -FINE_SPAN && q.coarse != 8'sh80) begin
                  n.coarse = q.coarse - 8'sh01;
                  fnew     = fraw + $signed({4'h0, coarse_step(q.gain)});
               end
               // fine absorbs the rest, code for code
               n.fine = sat_fine(fnew);
            end
         end
         default: n.st = CAL_IDLE;
      endcase
      // set wins over the end-of-line clear
      if (frame_rise && q.ctrl.fast)
         n.first = 1'b1;

      // bus side; both address and data must be offered together
      axi_wr      = q.axi.awready & awvalid & wvalid;
      n.axi.awready = awvalid && wvalid && !q.axi.awready && !q.axi.bvalid;
      n.axi.wready  = n.axi.awready;
      if (q.axi.bvalid && bready)
         n.axi.bvalid = 1'b0;
      if (axi_wr) begin
         n.axi.bvalid = 1'b1;
         n.axi.bresp  = mapped(awaddr[7:2]) ? RESP_OKAY : RESP_SLVERR;
      end
      n.axi.arready = arvalid && !q.axi.arready && !q.axi.rvalid;
      if (q.axi.rvalid && rready)
         n.axi.rvalid = 1'b0;
      if (q.axi.arready && arvalid) begin
         n.axi.rvalid = 1'b1;
         n.axi.rdata  = reg_read(q, araddr[7:2]);
         n.axi.rresp  = mapped(araddr[7:2]) ? RESP_OKAY : RESP_SLVERR;
      end

      // bus write wins over a serial frame in the same cycle
      wr_en   = axi_wr | ser_wr;
      wr_idx  = axi_wr ? awaddr[7:2] : {2'b00, ser_word[13:10]};
      wr_mask = axi_wr ? {{8{wstrb[3]}}, {8{wstrb[2]}},
                          {8{wstrb[1]}}, {8{wstrb[0]}}} : 32'h0000_03ff;
      wd      = axi_wr ? wdata : {22'h0, ser_word[9:0]};
      wd      = (reg_read(q, wr_idx) & ~wr_mask) | (wd & wr_mask);
      if (wr_en) begin
         unique case ({wr_idx, 2'b00})
            CTRL_OFS:   n.ctrl   = ctrl_t'(wd[7:0]);
            TARGET_OFS: n.target = wd[9:0];
            LIMIT_OFS: begin
               n.cold = wd[9:0];
               n.hot  = wd[HOT_LSB+9:HOT_LSB];
            end
            GAIN_OFS:   n.gain = (wd[9:0] > GAIN_MAX) ? GAIN_MAX : wd[9:0];
            // automatic mode resumes from these held values
            COARSE_OFS: n.coarse = wd[7:0];
            FINE_OFS:   n.fine   = sat_fine({{2{wd[9]}}, wd[9:0]});
            default:    ;
         endcase
      end
      // software reset leaves a pending bus answer intact
      if (wr_en && {wr_idx, 2'b00} == CTRL_OFS && wd[SRST_BIT]) begin
         keep   = n.axi;
         n      = rst_state();
         n.axi  = keep;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         q <= rst_state();
      else
         q <= n;
   end

   assign awready           = q.axi.awready;
   assign wready            = q.axi.wready;
   assign bvalid            = q.axi.bvalid;
   assign bresp             = q.axi.bresp;
   assign arready           = q.axi.arready;
   assign rvalid            = q.axi.rvalid;
   assign rdata             = q.axi.rdata;
   assign rresp             = q.axi.rresp;
   assign coarse_offset_dac = q.coarse;
   assign fine_offset_dac   = q.fine;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_last_px;
      q.st == CAL_RUN && conv_rise && q.cnt == last && !wr_en;
   endsequence
   sequence s_close;
      q.st == CAL_UPDATE ##1 q.st == CAL_IDLE;
   endsequence

   a_clamp_start: assert property (
      q.st == CAL_IDLE && clamp_fall && !q.ctrl.direct && !wr_en
      |=> q.st == CAL_RUN)
      else $error("clamp did not start a pass");
   a_window_close: assert property (
      s_last_px |=> s_close)
      else $error("averaging window length wrong");
   a_fine_span: assert property (
      q.fine <= 10'sh0ff && q.fine >= -10'sh0ff)
      else $error("fine dac outside span");
   a_fine_exact: assert property (
      q.st == CAL_UPDATE && !q.ctrl.direct && !wr_en
      && fraw <= FINE_SPAN && fraw >= -FINE_SPAN
      |=> q.fine == $past(fraw[9:0]) && $stable(q.coarse))
      else $error("fine correction not exact");
   a_coarse_one: assert property (
      q.st == CAL_UPDATE && !wr_en |=> q.coarse == $past(q.coarse)
      || q.coarse == $past(q.coarse) + 8'sh01
      || q.coarse == $past(q.coarse) - 8'sh01)
      else $error("coarse dac moved by more than one");
   a_fast_line: assert property (
      q.st == CAL_UPDATE && q.first && !wr_en
      |=> q.avg == {$past(line), 7'h00})
      else $error("fast line not single-line average");
   a_direct_hold: assert property (
      q.ctrl.direct && !wr_en |=> $stable(q.coarse) && $stable(q.fine))
      else $error("dac moved in direct mode");
   a_gain_max: assert property (
      q.gain <= GAIN_MAX)
      else $error("gain code above 767");
   a_serial_wr: assert property (
      ser_wr && !axi_wr && ser_word[13:10] == 4'h1
      |=> q.target == $past(ser_word[9:0]))
      else $error("serial frame not written");
   a_target_rst: assert property (
      @(posedge aclk) disable iff (1'b0)
      !aresetn |=> q.target == TARGET_RST)
      else $error("target reset value wrong");
endmodule : black_offset_cal
`default_nettype wire

// ### inc/offset_cal_pkg.sv
// Purpose: constants and types of the black-level offset calibration
// Assumes: AXI4-Lite register map, 10-bit converter codes
// Notes:   register offsets are byte addresses
package offset_cal_pkg;
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] TARGET_OFS = 8'h04;
   localparam logic [7:0] LIMIT_OFS  = 8'h08;
   localparam logic [7:0] GAIN_OFS   = 8'h0c;
   localparam logic [7:0] COARSE_OFS = 8'h10;
   localparam logic [7:0] FINE_OFS   = 8'h14;
   localparam logic [7:0] STATUS_OFS = 8'h18;
   localparam int         SRST_BIT    = 8;
   localparam int         HOT_LSB     = 16;
   localparam int         BUSY_BIT    = 16;
   localparam int         FIRST_BIT   = 17;
   localparam logic [7:0] CTRL_RST    = 8'h90;
   localparam logic [9:0] TARGET_RST  = 10'h040;
   localparam logic [9:0] HOT_RST     = 10'h3ff;
   localparam logic [9:0] COLD_RST    = 10'h000;
   localparam logic [9:0] GAIN_RST    = 10'h000;
   localparam logic [9:0] GAIN_MAX    = 10'h2ff;
   localparam logic [9:0] GAIN_N3     = 10'h040;
   localparam logic [9:0] GAIN_N2     = 10'h060;
   localparam logic [9:0] GAIN_N1     = 10'h080;
   localparam logic [2:0] N_LOG_MAX   = 3'h6;
   localparam int         FRAC        = 7;
   localparam logic signed [11:0] FINE_SPAN = 12'sh0ff;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {CAL_IDLE, CAL_RUN, CAL_UPDATE} cal_st_t;

   typedef struct packed {
      logic [2:0] n_log;
      logic [2:0] wshift;
      logic       fast;
      logic       direct;
   } ctrl_t;

   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
   } axi_t;

   typedef struct packed {
      logic [5:0]         s1;
      logic [5:0]         s2;
      logic [5:0]         s3;
      logic [9:0]         px1;
      logic [9:0]         px2;
      logic [15:0]        sh;
      logic [3:0]         bits;
      ctrl_t              ctrl;
      logic [9:0]         target;
      logic [9:0]         hot;
      logic [9:0]         cold;
      logic [9:0]         gain;
      logic signed [7:0]  coarse;
      logic signed [9:0]  fine;
      cal_st_t            st;
      logic [6:0]         cnt;
      logic [15:0]        sum;
      logic [9:0]         prev;
      logic               first;
      logic [16:0]        avg;
      axi_t               axi;
   } state_t;
endpackage : offset_cal_pkg

// ### tb/black_timing_model.sv
// Purpose: timing generator and analog chain in front of the loop
// Assumes: each clock half lasts 4 aclk cycles
// Notes:   the code follows the DAC outputs, so the loop closes
`timescale 1ns/1ps
`default_nettype none
module black_timing_model (
   input  wire logic       aclk,
   input  wire logic       go,
   input  wire logic       frame,
   input  wire logic       spike,
   input  wire logic [6:0] n_px,
   input  wire logic [9:0] raw,
   input  wire logic [3:0] step,
   input  wire logic [7:0] coarse,
   input  wire logic [9:0] fine,
   output logic            clamp_n,
   output logic            conv_clk,
   output logic            frame_pulse,
   output logic [9:0]      code,
   output logic            done
);
   int v;
   initial begin
      clamp_n = 1'b1;
      conv_clk = 1'b0;
      frame_pulse = 1'b0;
      code = 10'h000;
      done = 1'b0;
   end
   always @(posedge aclk) begin
      if (go) begin
         done <= 1'b0;
         if (frame) begin
            frame_pulse <= 1'b1;
            repeat (4) @(posedge aclk);
            frame_pulse <= 1'b0;
            repeat (4) @(posedge aclk);
         end
         // four pixel periods of quiet before the clamp falls
         repeat (32) @(posedge aclk);
         clamp_n <= 1'b0;
         for (int k = 0; k < n_px; k++) begin
            v = int'(raw) + int'($signed(fine));
            v = v + int'($signed(coarse)) * int'(step);
            if (spike && k == 1) begin
               v = v + 256;
            end
            code <= (v < 0) ? 10'h000 : (v > 1023) ? 10'h3ff : v[9:0];
            repeat (4) @(posedge aclk);
            conv_clk <= 1'b1;
            repeat (4) @(posedge aclk);
            conv_clk <= 1'b0;
            clamp_n <= 1'b1;
         end
         repeat (4) @(posedge aclk);
         // stale code would hide a late sample
         code <= ~code;
         done <= 1'b1;
      end
   end
endmodule : black_timing_model
`default_nettype wire

// ### tb/optical_black_offset_calibration_test.sv
// Purpose: self-checking bench of the black level offset loop
// Assumes: every scenario's average lands on a whole code
// Notes:   expected fine code is old fine minus (average - target), plus the coarse step in sc_coarse
`timescale 1ns/1ps
`default_nettype none
module optical_black_offset_calibration_test
   import offset_cal_pkg::*;
;
   logic        aclk, aresetn, awvalid, awready, wvalid, wready;
   logic        bvalid, bready, arvalid, arready, rvalid, rready;
   logic [7:0]  awaddr, araddr, coarse_offset_dac;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb, step;
   logic [1:0]  bresp, rresp;
   logic        black_clamp_pulse_n, conversion_clock, frame_start;
   logic        serial_clk, serial_cs_n, serial_data_in;
   logic        go, frame, spike, done;
   logic [6:0]  n_px;
   logic [9:0]  raw, adc_data, fine_offset_dac;
   int          n_errors = 0;
   int          total_checks = 0;
   logic [7:0]  r_ofs [8] = '{CTRL_OFS, TARGET_OFS, LIMIT_OFS, GAIN_OFS,
                              COARSE_OFS, FINE_OFS, STATUS_OFS, 8'h1c};
   logic [31:0] r_val [8] = '{32'h90, 32'h40, 32'h03ff0000, 32'h0,
                              32'h0, 32'h0, 32'h0, 32'h0};
   logic [9:0]  g_code [4] = '{10'h000, 10'h040, 10'h060, 10'h080};
   logic [3:0]  g_step [4] = '{4'h4, 4'h3, 4'h2, 4'h2};

   black_offset_cal black_offset_cal_inst (.aclk, .aresetn, .awvalid,
      .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid,
      .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready,
      .rdata, .rresp, .black_clamp_pulse_n, .conversion_clock,
      .frame_start, .adc_data, .serial_clk, .serial_cs_n,
      .serial_data_in, .coarse_offset_dac, .fine_offset_dac);
   black_timing_model black_timing_model_inst (.aclk, .go, .frame,
      .spike, .n_px, .raw, .step, .coarse(coarse_offset_dac),
      .fine(fine_offset_dac), .clamp_n(black_clamp_pulse_n),
      .conv_clk(conversion_clock), .frame_pulse(frame_start),
      .code(adc_data), .done);

   always #5 aclk = ~aclk;

   task automatic results;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : results

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic guard(inout int i);
      i++;
      if (i > 2000) begin
         n_errors++;
         $display("wait limit reached at t=%0t", $time);
         results();
      end
   endtask : guard

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      int i = 0;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      awaddr <= a;
      wdata <= d;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         guard(i);
      end while (awready !== 1'b1 || wready !== 1'b1);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      while (bvalid !== 1'b1) begin
         @(posedge aclk);
         guard(i);
      end
      r = bresp;
      bready <= 1'b0;
      @(posedge aclk);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      int i = 0;
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         guard(i);
      end while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) begin
         @(posedge aclk);
         guard(i);
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask : rd

   task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                       input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      chk(d, e);
      chk({30'h0, r}, {30'h0, er});
   endtask : rchk

   task automatic dac(input logic [7:0] c, input logic [9:0] f);
      chk({24'h0, coarse_offset_dac}, {24'h0, c});
      chk({22'h0, fine_offset_dac}, {22'h0, f});
   endtask : dac

   task automatic prep(input logic [31:0] c);
      logic [1:0] q;
      wr(CTRL_OFS, c, q);
      wr(COARSE_OFS, 32'h0, q);
      wr(FINE_OFS, 32'h0, q);
   endtask : prep

   task automatic ser(input logic [15:0] f);
      serial_cs_n <= 1'b0;
      for (int b = 15; b >= 0; b--) begin
         serial_data_in <= f[b];
         repeat (4) @(posedge aclk);
         serial_clk <= 1'b1;
         repeat (4) @(posedge aclk);
         serial_clk <= 1'b0;
      end
      serial_cs_n <= 1'b1;
      serial_data_in <= ~f[0];
      repeat (8) @(posedge aclk);
   endtask : ser

   task automatic line(input logic [9:0] r, input logic s,
                       input logic f, input logic [6:0] n);
      logic [31:0] d;
      logic [1:0]  q;
      int          i = 0;
      raw <= r;
      spike <= s;
      frame <= f;
      n_px <= n;
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      do begin
         @(posedge aclk);
         guard(i);
      end while (done !== 1'b1);
      do begin
         rd(STATUS_OFS, d, q);
         guard(i);
      end while (d[BUSY_BIT] !== 1'b0);
   endtask : line

   task automatic sc_reset;
      logic [1:0] q;
      logic [1:0] e;
      foreach (r_ofs[k]) begin
         e = (k == 7) ? RESP_SLVERR : RESP_OKAY;
         rchk(r_ofs[k], r_val[k], e);
      end
      wr(8'h20, 32'h1, q);
      chk({30'h0, q}, {30'h0, RESP_SLVERR});
      wr(GAIN_OFS, 32'h3ff, q);
      rchk(GAIN_OFS, 32'h2ff, RESP_OKAY);
      wr(GAIN_OFS, 32'h0, q);
   endtask : sc_reset

   task automatic sc_fine;
      prep(32'h40);
      line(10'h050, 1'b0, 1'b0, 7'd4);
      dac(8'h00, 10'h3f0);
      line(10'h050, 1'b0, 1'b0, 7'd4);
      dac(8'h00, 10'h3f0);
   endtask : sc_fine

   task automatic sc_count;
      prep(32'h00);
      line(10'h048, 1'b0, 1'b0, 7'd1);
      dac(8'h00, 10'h3f8);
      prep(32'hc0);
      line(10'h040, 1'b1, 1'b0, 7'd64);
      dac(8'h00, 10'h3fc);
   endtask : sc_count

   task automatic sc_coarse;
      logic [1:0] q;
      for (int k = 0; k < 4; k++) begin
         prep(32'h40);
         wr(GAIN_OFS, {22'h0, g_code[k]}, q);
         step <= g_step[k];
         line(10'h141, 1'b0, 1'b0, 7'd4);
         dac(8'hff, 10'h2ff + {6'h0, g_step[k]});
      end
      wr(GAIN_OFS, 32'h0, q);
      step <= 4'h4;
   endtask : sc_coarse

   task automatic sc_limits;
      logic [1:0] q;
      wr(LIMIT_OFS, 32'h0060_0000, q);
      prep(32'h40);
      line(10'h050, 1'b1, 1'b0, 7'd4);
      dac(8'h00, 10'h3f0);
      prep(32'h5e);
      line(10'h040, 1'b1, 1'b1, 7'd4);
      dac(8'h00, 10'h3c0);
      // factor 1/128 on a zero line: average 128 only falls to 127
      line(10'h040, 1'b0, 1'b0, 7'd4);
      dac(8'h00, 10'h381);
      wr(LIMIT_OFS, 32'h03ff_0000, q);
   endtask : sc_limits

   task automatic sc_direct;
      logic [1:0] q;
      wr(CTRL_OFS, 32'h41, q);
      wr(COARSE_OFS, 32'h1, q);
      wr(FINE_OFS, 32'h5, q);
      line(10'h040, 1'b0, 1'b0, 7'd4);
      dac(8'h01, 10'h005);
      wr(CTRL_OFS, 32'h40, q);
      line(10'h040, 1'b0, 1'b0, 7'd4);
      dac(8'h01, 10'h3fc);
      // offset of 12 codes: only the fine DAC is written
      wr(CTRL_OFS, 32'h41, q);
      wr(FINE_OFS, 32'h3f4, q);
      wr(CTRL_OFS, 32'h40, q);
      line(10'h048, 1'b0, 1'b0, 7'd4);
      dac(8'h01, 10'h3f4);
   endtask : sc_direct

   task automatic sc_serial;
      logic [1:0] q;
      ser({2'b00, 4'h1, 10'h055});
      rchk(TARGET_OFS, 32'h55, RESP_OKAY);
      ser({2'b01, 4'h1, 10'h066});
      rchk(TARGET_OFS, 32'h55, RESP_OKAY);
      wr(CTRL_OFS, 32'h100, q);
      rchk(TARGET_OFS, 32'h40, RESP_OKAY);
      dac(8'h00, 10'h000);
   endtask : sc_serial

   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      {go, frame, spike, serial_clk, serial_data_in} = '0;
      {awaddr, araddr, wdata, n_px, raw} = '0;
      serial_cs_n = 1'b1;
      wstrb = 4'hf;
      step = 4'h4;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      sc_reset();
      sc_fine();
      sc_count();
      sc_coarse();
      sc_limits();
      sc_direct();
      sc_serial();
      results();
   end
endmodule : optical_black_offset_calibration_test
`default_nettype wire
